// >>> bench/spm_board.sv
// Board model: strap resistors and pad level resolution.
// Assumes pad controls come straight from spm_top.
`timescale 1ns/10ps
`default_nettype none
`include "spm_defs.svh"

module spm_board (
    input  wire logic                  clk_i,
    input  wire logic [`SPM_N_PIN-1:0] pad_out_i,
    input  wire logic [`SPM_N_PIN-1:0] pad_oe_i,
    input  wire logic [`SPM_N_PIN-1:0] pull_en_i,
    input  wire logic [`SPM_N_PIN-1:0] pull_up_i,
    input  wire logic [2:0]            strap_i,
    output logic      [`SPM_N_PIN-1:0] pad_lvl_o
);
    logic flip_r = 1'b0;

    // Floating pins wander every cycle
    always_ff @(posedge clk_i) begin
        flip_r <= ~flip_r;
    end

    // Driver wins, then pull, then wander; strap resistors beat the weak pull
    always_comb begin
        for (int k = 0; k < `SPM_N_PIN; k++) begin
            pad_lvl_o[k] = pad_oe_i[k] ? pad_out_i[k] : pull_en_i[k] ? pull_up_i[k] : flip_r ^ k[0];
        end
        if (!pad_oe_i[`SPM_PIN_RO_BYP]) pad_lvl_o[`SPM_PIN_RO_BYP] = strap_i[0];
        if (!pad_oe_i[`SPM_PIN_RTC_BYP]) pad_lvl_o[`SPM_PIN_RTC_BYP] = strap_i[1];
        if (!pad_oe_i[`SPM_PIN_HALT]) pad_lvl_o[`SPM_PIN_HALT] = strap_i[2];
    end
endmodule
`default_nettype wire

// >>> bench/spm_chk.sv
// Checker for strap capture, pin defaults and bus answer.
// Assumes it is bound into spm_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "spm_defs.svh"

module spm_chk (
    input wire logic                              clk_i,
    input wire logic                              nrst_i,
    input wire logic                              resume_reset_n_i,
    input wire logic                              plat_reset_n_i,
    input wire logic                              psel_i,
    input wire logic                              penable_i,
    input wire logic                              pready_o,
    input wire logic                              pslverr_o,
    input wire spm_pkg::spm_fn_t [`SPM_N_PIN-1:0] fn_oe_i,
    input wire logic [`SPM_N_PIN-1:0]             pad_in_i,
    input wire logic [`SPM_N_PIN-1:0]             pad_oe_o,
    input wire logic [`SPM_N_PIN-1:0]             pull_en_o,
    input wire logic [`SPM_N_PIN-1:0]             pull_up_o,
    input wire logic                              ring_osc_bypass_o,
    input wire logic                              rtc_oscillator_bypass_o,
    input wire logic                              halt_boot_ok_o,
    input wire logic                              third_display_port_en_o,
    input wire logic                              straps_captured_o
);
    import spm_pkg::*;
    localparam logic [`SPM_N_PIN-1:0] PU_MASK = (192'h1 << 13) | (192'h1 << 14) | (192'h1 << 16);
    logic [2:0] hi_r;
    logic [2:0] hi_nxt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Cycles since resume reset release, saturating
    always_comb begin
        hi_nxt = !resume_reset_n_i ? 3'h0 : (hi_r == 3'h7) ? hi_r : hi_r + 3'h1;
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_r <= 3'h0;
        end else begin
            hi_r <= hi_nxt;
        end
    end

    property p_ready;
        psel_i && penable_i |-> pready_o;
    endproperty
    a_ready: assert property (p_ready) else $error("access phase without ready");
    property p_err;
        pslverr_o |-> psel_i && penable_i;
    endproperty
    a_err: assert property (p_err) else $error("error outside access phase");
    property p_disp3;
        third_display_port_en_o;
    endproperty
    a_disp3: assert property (p_disp3) else $error("third display port off");
    property p_capture;
        $rose(resume_reset_n_i) ##1 resume_reset_n_i [*5] |->
            straps_captured_o && halt_boot_ok_o == $past(pad_in_i[16], 5);
    endproperty
    a_capture: assert property (p_capture) else $error("strap not captured");
    property p_bypass;
        $rose(resume_reset_n_i) ##1 resume_reset_n_i [*5] |->
            ring_osc_bypass_o == $past(pad_in_i[11], 5) && rtc_oscillator_bypass_o == $past(pad_in_i[3], 5);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass strap value wrong");
    property p_hold;
        hi_r == 3'h7 |-> $stable({ring_osc_bypass_o, rtc_oscillator_bypass_o, halt_boot_ok_o, straps_captured_o});
    endproperty
    a_hold: assert property (p_hold) else $error("latched strap changed");
    property p_undriven;
        !resume_reset_n_i [*5] |-> !pad_oe_o[3] && !pad_oe_o[11] && !pad_oe_o[16]
            && pull_en_o[3] && pull_en_o[11] && pull_en_o[16];
    endproperty
    a_undriven: assert property (p_undriven) else $error("strap pin driven while sampled");
    property p_plat;
        !plat_reset_n_i [*6] |-> &pull_en_o && pull_up_o == PU_MASK
            && pad_oe_o[0] == $past(fn_oe_i[0][0]) && pad_oe_o[2] == $past(fn_oe_i[2][2]);
    endproperty
    a_plat: assert property (p_plat) else $error("pin not at default in platform reset");
endmodule

bind spm_top spm_chk u_spm_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .resume_reset_n_i(resume_reset_n_i), .plat_reset_n_i(plat_reset_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .fn_oe_i(fn_oe_i),
    .pad_in_i(pad_in_i), .pad_oe_o(pad_oe_o), .pull_en_o(pull_en_o), .pull_up_o(pull_up_o),
    .ring_osc_bypass_o(ring_osc_bypass_o), .rtc_oscillator_bypass_o(rtc_oscillator_bypass_o),
    .halt_boot_ok_o(halt_boot_ok_o), .third_display_port_en_o(third_display_port_en_o),
    .straps_captured_o(straps_captured_o)
);
`default_nettype wire

// >>> bench/tb_spm_top.sv
// Testbench for spm_top: defaults, straps, register map, pin mux.
// Assumes spm_board drives the pads and spm_chk is bound in.
`timescale 1ns/10ps
`default_nettype none
`include "spm_defs.svh"

module tb_spm_top;
    import spm_pkg::*;
    logic                     clk_i, nrst_i, resume_reset_n_i, plat_reset_n_i, er, eo;
    logic                     psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [`SPM_ADDR_W-1:0]   paddr_i;
    logic [`SPM_DATA_W-1:0]   pwdata_i, prdata_o, rd;
    spm_fn_t [`SPM_N_PIN-1:0] fn_out_i, fn_oe_i;
    logic [`SPM_N_PIN-1:0]    fn_in_o, pad_in_i, pad_out_o, pad_oe_o, pull_en_o, pull_up_o;
    logic                     ro_o, rtc_o, halt_o, disp_o, capt_o;
    logic [2:0]               strap_lvl, m;
    logic [6:0]               wd;
    int                       n_fail = 0, n_checks = 0, n;

    spm_top u_spm_top (
        .clk_i(clk_i), .nrst_i(nrst_i), .resume_reset_n_i(resume_reset_n_i), .plat_reset_n_i(plat_reset_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .fn_out_i(fn_out_i),
        .fn_oe_i(fn_oe_i), .fn_in_o(fn_in_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
        .pull_en_o(pull_en_o), .pull_up_o(pull_up_o), .ring_osc_bypass_o(ro_o), .rtc_oscillator_bypass_o(rtc_o),
        .halt_boot_ok_o(halt_o), .third_display_port_en_o(disp_o), .straps_captured_o(capt_o)
    );
    spm_board u_spm_board (
        .clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pull_en_i(pull_en_o),
        .pull_up_i(pull_up_o), .strap_i(strap_lvl), .pad_lvl_o(pad_in_i)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [6:0] def_cfg(input int k);
        return {2'b00, (k == 13 || k == 14 || k == 16), 1'b0, (k == 2) ? `SPM_ALT_DEF_MODE : `SPM_DEF_MODE};
    endfunction
    function automatic logic [11:0] pin_addr(input int k);
        return `SPM_PIN_BASE + 12'(4 * k);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until ready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic check_defaults();
        logic [6:0] e;
        for (int k = 0; k < `SPM_N_PIN; k++) begin
            e = def_cfg(k);
            apb(1'b0, pin_addr(k), 32'h0, rd, er);
            chk(rd[6:0], e);
            chk({pull_en_o[k], pull_up_o[k]}, {1'b1, e[4]});
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
    initial begin
        {nrst_i, resume_reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        plat_reset_n_i = 1'b1;
        strap_lvl = 3'b100;
        void'($urandom(45847));
        for (int k = 0; k < `SPM_N_PIN; k++) begin
            fn_out_i[k] = 7'($urandom);
            fn_oe_i[k] = (k == 3 || k == 11 || k == 16) ? 7'h0 : 7'($urandom);
        end
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        check_defaults();
        apb(1'b0, `SPM_STRAP_OFS, 32'h0, rd, er);
        chk(rd, 32'h8);
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, pin_addr(`SPM_PIN_HALT), 32'h60, rd, er);
            strap_lvl <= 3'(k) | 3'h4;
            resume_reset_n_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            chk(pad_oe_o[`SPM_PIN_HALT], 1'b0);
            resume_reset_n_i <= 1'b1;
            repeat (10) @(posedge clk_i);
            strap_lvl <= ~3'(k);
            repeat (4) @(posedge clk_i);
            apb(1'b0, `SPM_STRAP_OFS, 32'h0, rd, er);
            chk(rd, {27'h0, 3'b111, 2'(k)});
            chk({capt_o, disp_o, halt_o, rtc_o, ro_o}, {3'b111, 2'(k)});
        end
        apb(1'b1, `SPM_STRAP_OFS, 32'h0, rd, er);
        apb(1'b0, `SPM_STRAP_OFS, 32'h0, rd, er);
        chk(rd, 32'h1f);
        strap_lvl <= 3'b100;
        apb(1'b1, 12'h700, 32'hffffffff, rd, er);
        chk(er, 1'b1);
        apb(1'b0, 12'h004, 32'h0, rd, er);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        for (int i = 0; i < 40; i++) begin
            n = $urandom_range(`SPM_N_PIN - 1);
            if (n == 3 || n == 11 || n == 16) n = 0;
            wd = (i == 0) ? 7'h60 : 7'($urandom);
            m = wd[2:0];
            apb(1'b1, pin_addr(n), {25'h0, wd}, rd, er);
            chk(er, 1'b0);
            repeat (6) @(posedge clk_i);
            #1;
            chk({pull_en_o[n], pull_up_o[n]}, {~wd[3], wd[4]});
            eo = (m == 3'h0) ? wd[6] : fn_oe_i[n][m - 3'h1];
            chk({pad_oe_o[n], pad_out_o[n]}, {eo, (m == 3'h0) ? wd[5] : fn_out_i[n][m - 3'h1]});
            if (eo || !wd[3] || m == 3'h0) chk(fn_in_o[n], (m == 3'h0) ? 1'b0 : pad_in_i[n]);
            @(posedge clk_i);
            apb(1'b0, pin_addr(n), 32'h0, rd, er);
            chk(rd[7:0], {1'b0, wd});
            if (eo || !wd[3]) chk(rd[8], pad_in_i[n]);
        end
        plat_reset_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        apb(1'b1, pin_addr(0), 32'h60, rd, er);
        check_defaults();
        plat_reset_n_i <= 1'b1;
        final_report();
    end
endmodule
`default_nettype wire

// >>> logic/spm_pin_cell.sv
// One multiplexed pin: function select, termination, input sync.
// Assumes configuration comes from flops on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "spm_defs.svh"

module spm_pin_cell (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire spm_pkg::spm_cfg_t cfg_i,
    input  wire logic              strap_hold_i,
    input  wire spm_pkg::spm_fn_t  fn_out_i,
    input  wire spm_pkg::spm_fn_t  fn_oe_i,
    input  wire logic              pad_in_i,
    output logic                   pad_out_o,
    output logic                   pad_oe_o,
    output logic                   pull_en_o,
    output logic                   pull_up_o,
    output logic                   pad_lvl_o,
    output logic                   fn_in_o
);
    import spm_pkg::*;

    spm_mode_t mode;
    logic      sync1_r;
    logic      sync2_r;
    logic      out_nxt;
    logic      oe_nxt;
    logic      pen_nxt;
    logic      pup_nxt;
    logic      fin_nxt;
    logic      out_r;
    logic      oe_r;
    logic      pen_r;
    logic      pup_r;
    logic      fin_r;

    assign mode = cfg_i[`SPM_MODE_LSB +: `SPM_MODE_W];

    // ----------------------------------------
    // Output selection
    // ----------------------------------------
    // Mode 0 is plain GPIO, modes 1..7 pick a function slot
    always_comb begin
        if (mode == `SPM_MODE_GPIO) begin
            out_nxt = cfg_i[`SPM_GPIO_OUT_BIT];
            oe_nxt  = cfg_i[`SPM_GPIO_OE_BIT];
            fin_nxt = 1'b0;
        end else begin
            out_nxt = fn_out_i[mode - 3'h1];
            oe_nxt  = fn_oe_i[mode - 3'h1];
            fin_nxt = sync2_r;
        end
        if (strap_hold_i) begin
            oe_nxt = 1'b0;
        end
        pen_nxt = ~cfg_i[`SPM_TERM_DIS_BIT] | strap_hold_i;
        pup_nxt = cfg_i[`SPM_PULL_UP_BIT];
    end

    // Output flops and two-stage input synchroniser
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_r   <= 1'b0;
            oe_r    <= 1'b0;
            pen_r   <= 1'b1;
            pup_r   <= 1'b0;
            fin_r   <= 1'b0;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            out_r   <= out_nxt;
            oe_r    <= oe_nxt;
            pen_r   <= pen_nxt;
            pup_r   <= pup_nxt;
            fin_r   <= fin_nxt;
            sync1_r <= pad_in_i;
            sync2_r <= sync1_r;
        end
    end

    assign pad_out_o = out_r;
    assign pad_oe_o  = oe_r;
    assign pull_en_o = pen_r;
    assign pull_up_o = pup_r;
    assign pad_lvl_o = sync2_r;
    assign fn_in_o   = fin_r;

endmodule

`default_nettype wire

// >>> logic/spm_top.sv
// Strap latch and 192-pin function multiplexer with APB registers.
// Assumes pad buffers outside resolve out/oe/pull into the pin level,
// and that reset and pad inputs arrive asynchronously.
// Straps sit on pins 3, 11 and 16; every other pin is a plain mux pin.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "spm_defs.svh"

module spm_top (
    input  wire logic                              clk_i,
    input  wire logic                              nrst_i,
    input  wire logic                              resume_reset_n_i,
    input  wire logic                              plat_reset_n_i,
    input  wire logic                              psel_i,
    input  wire logic                              penable_i,
    input  wire logic                              pwrite_i,
    input  wire logic [`SPM_ADDR_W-1:0]            paddr_i,
    input  wire logic [`SPM_DATA_W-1:0]            pwdata_i,
    output logic      [`SPM_DATA_W-1:0]            prdata_o,
    output logic                                   pready_o,
    output logic                                   pslverr_o,
    input  wire spm_pkg::spm_fn_t [`SPM_N_PIN-1:0] fn_out_i,
    input  wire spm_pkg::spm_fn_t [`SPM_N_PIN-1:0] fn_oe_i,
    output logic      [`SPM_N_PIN-1:0]             fn_in_o,
    input  wire logic [`SPM_N_PIN-1:0]             pad_in_i,
    output logic      [`SPM_N_PIN-1:0]             pad_out_o,
    output logic      [`SPM_N_PIN-1:0]             pad_oe_o,
    output logic      [`SPM_N_PIN-1:0]             pull_en_o,
    output logic      [`SPM_N_PIN-1:0]             pull_up_o,
    output logic                                   ring_osc_bypass_o,
    output logic                                   rtc_oscillator_bypass_o,
    output logic                                   halt_boot_ok_o,
    output logic                                   third_display_port_en_o,
    output logic                                   straps_captured_o
);
    import spm_pkg::*;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Default configuration word of one pin
    // Pins 13, 14 and 16 pull up, all others pull down
    function automatic spm_cfg_t default_cfg(input spm_idx_t idx);
        spm_cfg_t c;
        c = '0;
        c[`SPM_MODE_LSB +: `SPM_MODE_W] = (idx == `SPM_PIN_ALT_DEF) ? `SPM_ALT_DEF_MODE : `SPM_DEF_MODE;
        c[`SPM_PULL_UP_BIT] = (idx == `SPM_PIN_PU_A) || (idx == `SPM_PIN_PU_B) || (idx == `SPM_PIN_HALT);
        return c;
    endfunction

    // Address lands on a pin configuration word
    function automatic logic is_pin(input logic [`SPM_ADDR_W-1:0] a);
        return (a[11:10] == `SPM_PIN_SEL_HI) && (a[1:0] == 2'h0) && (a[9:2] < 8'(`SPM_N_PIN));
    endfunction

    // Pin index of a pin configuration address
    function automatic spm_idx_t pin_idx(input logic [`SPM_ADDR_W-1:0] a);
        return a[9:2];
    endfunction

    // ----------------------------------------
    // Reset input synchronisers
    // ----------------------------------------
    logic rsm1_r;
    logic rsm2_r;
    logic rsm3_r;
    logic plt1_r;
    logic plt2_r;
    logic rsm1_nxt;
    logic rsm2_nxt;
    logic rsm3_nxt;
    logic plt1_nxt;
    logic plt2_nxt;
    logic rsm_rise;

    // Shift both reset pins along their chains
    always_comb begin
        rsm1_nxt = resume_reset_n_i;
        rsm2_nxt = rsm1_r;
        rsm3_nxt = rsm2_r;
        plt1_nxt = plat_reset_n_i;
        plt2_nxt = plt1_r;
    end

    // Two flops each, third flop for the resume edge
    // Chains reset low, so a resume pin already high at power-on
    // still gives one clean rising edge and the straps are captured
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsm1_r <= 1'b0;
            rsm2_r <= 1'b0;
            rsm3_r <= 1'b0;
            plt1_r <= 1'b0;
            plt2_r <= 1'b0;
        end else begin
            rsm1_r <= rsm1_nxt;
            rsm2_r <= rsm2_nxt;
            rsm3_r <= rsm3_nxt;
            plt1_r <= plt1_nxt;
            plt2_r <= plt2_nxt;
        end
    end

    // High for exactly one cycle per resume release
    assign rsm_rise = rsm2_r & ~rsm3_r;

    // ----------------------------------------
    // Pin configuration registers
    // ----------------------------------------
    spm_cfg_t                   cfg_r   [`SPM_N_PIN];
    spm_cfg_t                   cfg_nxt [`SPM_N_PIN];
    logic     [`SPM_N_PIN-1:0]  pad_lvl;
    logic     [`SPM_N_PIN-1:0]  strap_hold;
    logic                       wr_en;
    logic                       wr_pin;
    spm_idx_t                   wr_idx;

    assign wr_en  = psel_i & penable_i & pwrite_i;
    assign wr_pin = wr_en & is_pin(paddr_i);
    assign wr_idx = pin_idx(paddr_i);

    // Next configuration per pin
    // Platform reset wins over a write landing in the same cycle
    always_comb begin
        for (int i = 0; i < `SPM_N_PIN; i++) begin
            cfg_nxt[i] = cfg_r[i];
            if (!plt2_r) begin
                cfg_nxt[i] = default_cfg(spm_idx_t'(i));
            end else if (wr_pin && (wr_idx == spm_idx_t'(i))) begin
                cfg_nxt[i] = pwdata_i[`SPM_CFG_W-1:0];
            end
        end
    end

    // Configuration flops, defaults at power-on
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < `SPM_N_PIN; i++) begin
                cfg_r[i] <= default_cfg(spm_idx_t'(i));
            end
        end else begin
            for (int i = 0; i < `SPM_N_PIN; i++) begin
                cfg_r[i] <= cfg_nxt[i];
            end
        end
    end

    // ----------------------------------------
    // Strap hold while sampling
    // ----------------------------------------
    // Held from resume fall until one cycle after the capture edge
    // strap pins input-only before capture
    always_comb begin
        strap_hold                 = '0;
        strap_hold[`SPM_PIN_RO_BYP]  = ~rsm3_r;
        strap_hold[`SPM_PIN_RTC_BYP] = ~rsm3_r;
        strap_hold[`SPM_PIN_HALT]    = ~rsm3_r;
    end

    // ----------------------------------------
    // Pin cells
    // ----------------------------------------
    // Each cell registers its own pad controls and input sync
    // 192 multiplexed pins
    generate
        for (genvar g = 0; g < `SPM_N_PIN; g++) begin : g_pin
            spm_pin_cell u_cell (
                .clk_i        (clk_i),
                .nrst_i       (nrst_i),
                .cfg_i        (cfg_r[g]),
                .strap_hold_i (strap_hold[g]),
                .fn_out_i     (fn_out_i[g]),
                .fn_oe_i      (fn_oe_i[g]),
                .pad_in_i     (pad_in_i[g]),
                .pad_out_o    (pad_out_o[g]),
                .pad_oe_o     (pad_oe_o[g]),
                .pull_en_o    (pull_en_o[g]),
                .pull_up_o    (pull_up_o[g]),
                .pad_lvl_o    (pad_lvl[g]),
                .fn_in_o      (fn_in_o[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Strap latch
    // ----------------------------------------
    logic ro_byp_r;
    logic ro_byp_nxt;
    logic rtc_byp_r;
    logic rtc_byp_nxt;
    logic halt_r;
    logic halt_nxt;
    logic capt_r;
    logic capt_nxt;
    logic disp3_r;

    // Every resume release captures again; nrst clears to zeros until the resume chain next rises
    // capture on resume release
    always_comb begin
        ro_byp_nxt  = ro_byp_r;
        rtc_byp_nxt = rtc_byp_r;
        halt_nxt    = halt_r;
        capt_nxt    = capt_r;
        if (rsm_rise) begin
            ro_byp_nxt  = pad_lvl[`SPM_PIN_RO_BYP];
            rtc_byp_nxt = pad_lvl[`SPM_PIN_RTC_BYP];
            halt_nxt    = pad_lvl[`SPM_PIN_HALT];
            capt_nxt    = 1'b1;
        end
    end

    // Display enable kept in a flop so every status bit is registered
    // Latched strap values
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ro_byp_r  <= `SPM_STRAP_RST;
            rtc_byp_r <= `SPM_STRAP_RST;
            halt_r    <= `SPM_STRAP_RST;
            capt_r    <= 1'b0;
            disp3_r   <= `SPM_DISP3_RST;
        end else begin
            ro_byp_r  <= ro_byp_nxt;
            rtc_byp_r <= rtc_byp_nxt;
            halt_r    <= halt_nxt;
            capt_r    <= capt_nxt;
            disp3_r   <= `SPM_DISP3_RST;
        end
    end

    assign ring_osc_bypass_o       = ro_byp_r;
    assign rtc_oscillator_bypass_o        = rtc_byp_r;
    assign halt_boot_ok_o          = halt_r;
    assign third_display_port_en_o = disp3_r;
    assign straps_captured_o       = capt_r;

    // ----------------------------------------
    // APB read path
    // ----------------------------------------
    logic [`SPM_DATA_W-1:0] rdata_r;
    logic [`SPM_DATA_W-1:0] rdata_nxt;
    logic                   setup;
    logic                   hit_strap;
    spm_idx_t               rd_idx;

    assign setup     = psel_i & ~penable_i;
    assign hit_strap = (paddr_i == `SPM_STRAP_OFS);
    assign rd_idx    = pin_idx(paddr_i);

    // Read word prepared during the setup cycle
    // An out-of-range index never reaches the array: is_pin guards it
    always_comb begin
        rdata_nxt = rdata_r;
        if (setup && !pwrite_i) begin
            rdata_nxt = '0;
            if (hit_strap) begin
                rdata_nxt[`SPM_ST_RO_BYP]    = ro_byp_r;
                rdata_nxt[`SPM_ST_RTC_BYP]   = rtc_byp_r;
                rdata_nxt[`SPM_ST_HALT_BOOT] = halt_r;
                rdata_nxt[`SPM_ST_DISP3_EN]  = disp3_r;
                rdata_nxt[`SPM_ST_CAPTURED]  = capt_r;
            end else if (is_pin(paddr_i)) begin
                rdata_nxt[`SPM_CFG_W-1:0]    = cfg_r[rd_idx];
                rdata_nxt[`SPM_PAD_IN_BIT]   = pad_lvl[rd_idx];
            end
        end
    end

    // Read data flop
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Zero-wait answer, error on unmapped address
    // A write to the strap word is dropped without an error
    assign prdata_o  = rdata_r;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit_strap & ~is_pin(paddr_i);

endmodule

`default_nettype wire

// >>> shared/spm_defs.svh
// Constants for the strap latch and pin multiplexer.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define SPM_N_PIN         192
`define SPM_N_FN          7
`define SPM_ADDR_W        12
`define SPM_DATA_W        32
`define SPM_IDX_W         8

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPM_STRAP_OFS     12'h000
`define SPM_PIN_BASE      12'h400
`define SPM_PIN_SEL_HI    2'h1

// ----------------------------------------
// Pin configuration word fields
// ----------------------------------------
`define SPM_MODE_LSB      0
`define SPM_MODE_W        3
`define SPM_TERM_DIS_BIT  3
`define SPM_PULL_UP_BIT   4
`define SPM_GPIO_OUT_BIT  5
`define SPM_GPIO_OE_BIT   6
`define SPM_PAD_IN_BIT    8
`define SPM_CFG_W         7

// ----------------------------------------
// Strap status word fields
// ----------------------------------------
`define SPM_ST_RO_BYP     0
`define SPM_ST_RTC_BYP    1
`define SPM_ST_HALT_BOOT  2
`define SPM_ST_DISP3_EN   3
`define SPM_ST_CAPTURED   4

// ----------------------------------------
// Pin indices and defaults
// ----------------------------------------
`define SPM_PIN_RTC_BYP   8'd3
`define SPM_PIN_RO_BYP    8'd11
`define SPM_PIN_HALT      8'd16
`define SPM_PIN_ALT_DEF   8'd2
`define SPM_PIN_PU_A      8'd13
`define SPM_PIN_PU_B      8'd14
`define SPM_MODE_GPIO     3'h0
`define SPM_DEF_MODE      3'h1
`define SPM_ALT_DEF_MODE  3'h3
`define SPM_STRAP_RST     1'b0
`define SPM_DISP3_RST     1'b1

`endif

// >>> shared/spm_pkg.sv
// Types shared by the strap latch and pin multiplexer.
// Assumes spm_defs.svh is on the include path.
`include "spm_defs.svh"

package spm_pkg;
    typedef logic [`SPM_MODE_W-1:0] spm_mode_t;
    typedef logic [`SPM_CFG_W-1:0]  spm_cfg_t;
    typedef logic [`SPM_N_FN-1:0]   spm_fn_t;
    typedef logic [`SPM_IDX_W-1:0]  spm_idx_t;
endpackage
